// [core/auxmem_cfg.svh]
// Constants of the aux RAM and external memory access block
`ifndef AUXMEM_CFG_SVH
`define AUXMEM_CFG_SVH

// ***********************************************
// Special function register offsets and resets
// ***********************************************
`define AUXMEM_OFS_AUX_HIGH     8'hA1
`define AUXMEM_OFS_CHIP_CTRL    8'hBF
`define AUXMEM_OFS_CHIP_UNLOCK  8'hF6
`define AUXMEM_RST_AUX_HIGH     8'h00
`define AUXMEM_RST_CHIP_CTRL    8'h00
`define AUXMEM_UNLOCK_KEY1      8'h87
`define AUXMEM_UNLOCK_KEY2      8'h59
`define AUXMEM_LOCK_KEY         8'h00
`define AUXMEM_AUX_EN_BIT       4

// ***********************************************
// Memory sizes and address limits
// ***********************************************
`define AUXMEM_SCR_DEPTH        256
`define AUXMEM_SCR_AW           8
`define AUXMEM_AUX_DEPTH        1024
`define AUXMEM_AUX_AW           10
`define AUXMEM_AUX_LAST         16'h03FF
`define AUXMEM_DIRECT_LIMIT     8'h80

// ***********************************************
// Timing counts in core clocks (oscillator rate)
// ***********************************************
`define AUXMEM_ALE_DIV          6
`define AUXMEM_ALE_HIGH         2
`define AUXMEM_MACH_CYCLE       12
`define AUXMEM_RST_HOLD         (2 * `AUXMEM_MACH_CYCLE)

`endif

// [core/auxmem_pkg.sv]
// Types of the aux RAM and external memory access block
package auxmem_pkg;

   // Block sequencer states
   typedef enum logic [1:0] {
      AUXMEM_IDLE  = 2'b00,
      AUXMEM_AUX   = 2'b01,
      AUXMEM_EXT   = 2'b10,
      AUXMEM_FINT  = 2'b11
   } auxmem_state_t;

   // Pins of the multiplexed external bus, driven by the block
   typedef struct packed {
      logic       ale;       // Address latch strobe
      logic       program_store_strobe_n;    // Program store strobe, low active
      logic       rd_n;      // Data read strobe, low active
      logic       wr_n;      // Data write strobe, low active
      logic [7:0] p0_out;    // Port 0 low address / write data
      logic       p0_oe;     // Port 0 driven while high
      logic [7:0] p2_out;    // Port 2 upper address byte
   } auxmem_bus_t;

endpackage

// [core/auxmem_ram.sv]
// Single-port RAM with registered read data
`timescale 1ns/100ps
module auxmem_ram #(
   parameter int AW    = 8,
   parameter int DEPTH = 256
) (
   input  wire logic          core_clk_i,  // Core clock
   input  wire logic          en_i,        // Access enable
   input  wire logic          we_i,        // Write when enabled
   input  wire logic [AW-1:0] addr_i,      // Word address
   input  wire logic [7:0]    wdata_i,     // Write data
   output logic      [7:0]    rdata_o      // Registered read data
);

   logic [7:0] mem [DEPTH];

   // Read-before-write port; contents are not reset, like real RAM
   always_ff @(posedge core_clk_i) begin
      if (en_i) begin
         if (we_i) begin
            mem[addr_i] <= wdata_i;
         end
         rdata_o <= mem[addr_i];
      end
   end

endmodule

// [core/auxmem_top.sv]
// Data-memory steering and external bus strobes of the core
//
// Function
// - Select pin high keeps fetches off the bus; low forces external fetch.
// - Program strobe only gates external ROM data; none on internal fetches.
// - Latch strobe runs continuously at one sixth of the oscillator rate.
// - Latch strobe lets an outside latch take the port 0 low address first.
// - Port 2 carries the upper address byte during every external access.
// - Reset acts once the pin stays high two machine cycles; others hold it.
// - Separate 64K program and data spaces with 16-bit addresses.
// - On-chip data RAM: 256-byte scratchpad and separate 1K auxiliary RAM.
// - Scratchpad lower half reachable directly and through R0/R1.
// - Scratchpad upper half reachable only through R0/R1, not directly.
// - Data moves to 0..3FF use on-chip aux RAM via R0/R1 or data pointer.
// - Data moves above aux range run a normal external data cycle.
// - Aux RAM routing only while chip control bit 4 set; else external.
// - Aux RAM accesses leave ports 0, 2 and read/write strobes alone.
// - Chip control clears on reset, so aux routing starts disabled.
`timescale 1ns/100ps
`include "auxmem_cfg.svh"
module auxmem_top
   import auxmem_pkg::*;
(
   input  wire logic        core_clk_i,   // Oscillator-rate core clock
   input  wire logic        rst_i,        // Reset pin, high active
   input  wire logic        ea_n_i,       // External access select, low
   // Scratchpad / special function register port
   input  wire logic        sp_req_i,     // One-cycle access pulse
   input  wire logic        sp_we_i,      // Write access
   input  wire logic        sp_ind_i,     // Indirect (R0/R1) access
   input  wire logic [7:0]  sp_addr_i,    // Direct address or pointer
   input  wire logic [7:0]  sp_wdata_i,   // Write data
   output logic      [7:0]  sp_rdata_o,   // Read data, cycle after req
   output logic             sfr_hit_o,    // Direct hit on our registers
   // External data move port
   input  wire logic        mv_req_i,     // Held until mv_done_o
   input  wire logic        mv_we_i,      // Write move
   input  wire logic        mv_data_pointer_i,    // Address from data pointer
   input  wire logic [7:0]  mv_ptr_i,     // R0/R1 value
   input  wire logic [15:0] mv_data_pointer_val_i,// Data pointer value
   input  wire logic [7:0]  mv_wdata_i,   // Write data
   output logic      [7:0]  mv_rdata_o,   // Read data
   output logic             mv_done_o,    // One-cycle completion
   // Program fetch port
   input  wire logic        fe_req_i,     // Held until fe_done_o
   input  wire logic [15:0] fe_addr_i,    // Program address
   output logic      [7:0]  fe_data_o,    // External ROM byte
   output logic             fe_int_o,     // Fetch is from internal ROM
   output logic             fe_done_o,    // One-cycle completion
   // External bus
   input  wire logic [7:0]  p0_in_i,      // Port 0 pin levels
   output auxmem_bus_t      bus_o         // Bus pins
);

   // ***********************************************
   // Reset filter
   // ***********************************************
   localparam int RH = `AUXMEM_RST_HOLD;
   logic [RH-1:0] rst_hist;
   logic [RH-1:0] next_rst_hist;
   logic          irst;

   // Short glitches never reach the state below
   always_comb begin
      next_rst_hist = {rst_hist[RH-2:0], rst_i};
   end
   always_ff @(posedge core_clk_i) begin
      rst_hist <= next_rst_hist;
   end
   assign irst = &rst_hist;

   // ***********************************************
   // Address latch divider
   // ***********************************************
   logic [2:0] phase;
   logic [2:0] next_phase;
   logic       slot_start;

   // Free-running; the strobe never stops, even with no bus cycle
   always_comb begin
      next_phase = (phase == 3'(`AUXMEM_ALE_DIV - 1)) ? 3'h0
                                                      : phase + 3'h1;
   end
   always_ff @(posedge core_clk_i) begin
      if (irst) begin
         phase <= 3'h0;
      end else begin
         phase <= next_phase;
      end
   end
   assign slot_start = (phase == 3'h0);

   // ***********************************************
   // Special function registers
   // ***********************************************
   logic [7:0] aux_high;
   logic [7:0] chip_ctrl;
   logic [1:0] unlock;        // 0 locked, 1 first key seen, 2 open
   logic [7:0] next_aux_high;
   logic [7:0] next_chip_ctrl;
   logic [1:0] next_unlock;
   logic       dir_wr;
   logic       dir_sfr;

   assign dir_sfr = sp_req_i && !sp_ind_i &&
                    (sp_addr_i >= `AUXMEM_DIRECT_LIMIT);
   assign dir_wr  = dir_sfr && sp_we_i;

   // Unlock walks key1, key2; any other write to the key port relocks
   always_comb begin
      next_aux_high  = aux_high;
      next_chip_ctrl = chip_ctrl;
      next_unlock    = unlock;
      if (dir_wr) begin
         if (sp_addr_i == `AUXMEM_OFS_AUX_HIGH) begin
            next_aux_high = sp_wdata_i;
         end
         if (sp_addr_i == `AUXMEM_OFS_CHIP_CTRL && unlock == 2'd2) begin
            next_chip_ctrl = sp_wdata_i;
         end
         if (sp_addr_i == `AUXMEM_OFS_CHIP_UNLOCK) begin
            if (unlock == 2'd0 && sp_wdata_i == `AUXMEM_UNLOCK_KEY1) begin
               next_unlock = 2'd1;
            end else if (unlock == 2'd1 &&
                         sp_wdata_i == `AUXMEM_UNLOCK_KEY2) begin
               next_unlock = 2'd2;
            end else begin
               next_unlock = 2'd0;
            end
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (irst) begin
         aux_high  <= `AUXMEM_RST_AUX_HIGH;
         chip_ctrl <= `AUXMEM_RST_CHIP_CTRL;
         unlock    <= 2'd0;
      end else begin
         aux_high  <= next_aux_high;
         chip_ctrl <= next_chip_ctrl;
         unlock    <= next_unlock;
      end
   end

   // ***********************************************
   // Data move steering
   // ***********************************************
   logic [15:0] mv_addr;
   logic        mv_aux;

   // R0/R1 moves borrow the upper byte from the high-address register
   assign mv_addr = mv_data_pointer_i ? mv_data_pointer_val_i
                              : {aux_high, mv_ptr_i};
   assign mv_aux  = chip_ctrl[`AUXMEM_AUX_EN_BIT] &&
                    (mv_addr <= `AUXMEM_AUX_LAST);

   // ***********************************************
   // Sequencer and external bus
   // ***********************************************
   auxmem_state_t state;
   auxmem_state_t next_state;
   logic          is_fetch;
   logic          next_is_fetch;
   logic [15:0]   ext_addr;
   logic [15:0]   next_ext_addr;
   logic [7:0]    ext_wd;
   logic [7:0]    next_ext_wd;
   logic          ext_we;
   logic          next_ext_we;
   logic [7:0]    ext_rd;
   logic [7:0]    next_ext_rd;
   auxmem_bus_t   next_bus;

   // Data moves win over fetches; external cycles wait for a slot edge
   always_comb begin
      next_state    = state;
      next_is_fetch = is_fetch;
      next_ext_addr = ext_addr;
      next_ext_wd   = ext_wd;
      next_ext_we   = ext_we;
      next_ext_rd   = ext_rd;
      unique case (state)
         AUXMEM_IDLE: begin
            if (mv_req_i && mv_aux) begin
               next_state = AUXMEM_AUX;
            end else if (mv_req_i && slot_start) begin
               next_state    = AUXMEM_EXT;
               next_is_fetch = 1'b0;
               next_ext_addr = mv_addr;
               next_ext_wd   = mv_wdata_i;
               next_ext_we   = mv_we_i;
            end else if (fe_req_i && !mv_req_i && ea_n_i) begin
               next_state = AUXMEM_FINT;
            end else if (fe_req_i && !mv_req_i && slot_start) begin
               next_state    = AUXMEM_EXT;
               next_is_fetch = 1'b1;
               next_ext_addr = fe_addr_i;
               next_ext_we   = 1'b0;
            end
         end
         AUXMEM_AUX: begin
            next_state = AUXMEM_IDLE;
         end
         AUXMEM_EXT: begin
            if (phase == 3'(`AUXMEM_ALE_DIV - 1)) begin
               next_ext_rd = p0_in_i;
               next_state  = AUXMEM_IDLE;
            end
         end
         AUXMEM_FINT: begin
            next_state = AUXMEM_IDLE;
         end
      endcase
   end

   // Pin values one cycle ahead, so every pin leaves a flip-flop
   always_comb begin
      next_bus        = bus_o;
      next_bus.ale    = (next_phase < 3'(`AUXMEM_ALE_HIGH));
      next_bus.program_store_strobe_n = 1'b1;
      next_bus.rd_n   = 1'b1;
      next_bus.wr_n   = 1'b1;
      next_bus.p0_oe  = 1'b0;
      if (next_state == AUXMEM_EXT) begin
         next_bus.p2_out = next_ext_addr[15:8];
         if (next_bus.ale) begin
            // Low address stands while the latch strobe is high
            next_bus.p0_out = next_ext_addr[7:0];
            next_bus.p0_oe  = 1'b1;
         end else if (next_is_fetch) begin
            next_bus.program_store_strobe_n = 1'b0;
         end else if (next_ext_we) begin
            next_bus.wr_n   = 1'b0;
            next_bus.p0_out = next_ext_wd;
            next_bus.p0_oe  = 1'b1;
         end else begin
            next_bus.rd_n = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (irst) begin
         state    <= AUXMEM_IDLE;
         is_fetch <= 1'b0;
         ext_addr <= 16'h0000;
         ext_wd   <= 8'h00;
         ext_we   <= 1'b0;
         ext_rd   <= 8'h00;
         bus_o    <= '{ale: 1'b1, program_store_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                       p0_out: 8'hFF, p0_oe: 1'b0, p2_out: 8'hFF};
      end else begin
         state    <= next_state;
         is_fetch <= next_is_fetch;
         ext_addr <= next_ext_addr;
         ext_wd   <= next_ext_wd;
         ext_we   <= next_ext_we;
         ext_rd   <= next_ext_rd;
         bus_o    <= next_bus;
      end
   end

   // ***********************************************
   // On-chip RAM banks
   // ***********************************************
   logic [7:0] scr_rd;
   logic [7:0] aux_rd;
   logic       scr_en;
   logic       aux_en;

   assign scr_en = sp_req_i && (sp_ind_i ||
                   (sp_addr_i < `AUXMEM_DIRECT_LIMIT));
   assign aux_en = (state == AUXMEM_IDLE) && mv_req_i && mv_aux;

   auxmem_ram #(.AW(`AUXMEM_SCR_AW), .DEPTH(`AUXMEM_SCR_DEPTH)) u_scr (
      .core_clk_i (core_clk_i),
      .en_i       (scr_en),
      .we_i       (sp_we_i),
      .addr_i     (sp_addr_i),
      .wdata_i    (sp_wdata_i),
      .rdata_o    (scr_rd)
   );

   auxmem_ram #(.AW(`AUXMEM_AUX_AW), .DEPTH(`AUXMEM_AUX_DEPTH)) u_aux (
      .core_clk_i (core_clk_i),
      .en_i       (aux_en),
      .we_i       (mv_we_i),
      .addr_i     (mv_addr[`AUXMEM_AUX_AW-1:0]),
      .wdata_i    (mv_wdata_i),
      .rdata_o    (aux_rd)
   );

   // ***********************************************
   // Answers to the core
   // ***********************************************
   logic       sp_sel_sfr;
   logic [7:0] sfr_rd;
   logic       next_sp_sel_sfr;
   logic [7:0] next_sfr_rd;
   logic       next_sfr_hit;
   logic       ext_done_q;
   logic       next_ext_done;

   // Unlock port is write-only and reads as zero
   always_comb begin
      next_sp_sel_sfr = dir_sfr;
      next_sfr_hit    = 1'b0;
      next_sfr_rd     = 8'h00;
      if (dir_sfr && sp_addr_i == `AUXMEM_OFS_AUX_HIGH) begin
         next_sfr_rd  = aux_high;
         next_sfr_hit = 1'b1;
      end else if (dir_sfr && sp_addr_i == `AUXMEM_OFS_CHIP_CTRL) begin
         next_sfr_rd  = chip_ctrl;
         next_sfr_hit = 1'b1;
      end else if (dir_sfr && sp_addr_i == `AUXMEM_OFS_CHIP_UNLOCK) begin
         next_sfr_hit = 1'b1;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (irst) begin
         sp_sel_sfr <= 1'b0;
         sfr_rd     <= 8'h00;
         sfr_hit_o  <= 1'b0;
      end else begin
         sp_sel_sfr <= next_sp_sel_sfr;
         sfr_rd     <= next_sfr_rd;
         sfr_hit_o  <= next_sfr_hit;
      end
   end

   // Selection between registered sources; no logic after the RAMs
   assign sp_rdata_o = sp_sel_sfr ? sfr_rd : scr_rd;
   assign mv_rdata_o = (state == AUXMEM_AUX) ? aux_rd : ext_rd;
   assign fe_data_o  = ext_rd;
   assign fe_int_o   = (state == AUXMEM_FINT);
   assign fe_done_o  = (state == AUXMEM_FINT) ||
                       (state == AUXMEM_IDLE && is_fetch &&
                        phase == 3'h0 && bus_o.ale && ext_done_q);
   assign mv_done_o  = (state == AUXMEM_AUX) ||
                       (state == AUXMEM_IDLE && !is_fetch &&
                        phase == 3'h0 && bus_o.ale && ext_done_q);

   // Marks the one cycle right after an external cycle ends
   always_comb begin
      next_ext_done = (state == AUXMEM_EXT) && (next_state == AUXMEM_IDLE);
   end
   always_ff @(posedge core_clk_i) begin
      if (irst) begin
         ext_done_q <= 1'b0;
      end else begin
         ext_done_q <= next_ext_done;
      end
   end

endmodule

// [verif/auxmem_checker.sv]
// Port assertions for the aux RAM and external bus block
`timescale 1ns/100ps
module auxmem_checker
   import auxmem_pkg::*;
(
   input wire logic        core_clk_i,    // Clock
   input wire logic        rst_i,         // Reset pin
   input wire logic        ea_n_i,        // Fetch source select
   input wire logic        sp_req_i,      // Register access
   input wire logic        sp_ind_i,      // Indirect access
   input wire logic [7:0]  sp_addr_i,     // Access address
   input wire logic        sfr_hit_o,     // Register hit
   input wire logic        mv_req_i,      // Move request
   input wire logic        mv_data_pointer_i,     // Pointer select
   input wire logic [7:0]  mv_ptr_i,      // R0/R1 value
   input wire logic [15:0] mv_data_pointer_val_i, // Data pointer
   input wire logic        mv_done_o,     // Move done
   input wire logic        fe_req_i,      // Fetch request
   input wire logic [15:0] fe_addr_i,     // Fetch address
   input wire logic        fe_int_o,      // Internal fetch
   input wire logic        fe_done_o,     // Fetch done
   input wire auxmem_bus_t bus_o          // Bus pins
);
   // ***********************************************
   // Bus timing and routing
   // ***********************************************
   // Internal reset is not visible here, so the pin gates everything
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   ale_rate_a: assert property (
      $fell(bus_o.ale) |-> (!bus_o.ale) [*4] ##1 bus_o.ale [*2] ##1 !bus_o.ale)
      else $error("latch strobe off its six clock rhythm");
   program_store_strobe_int_a: assert property (
      ea_n_i [*8] |-> bus_o.program_store_strobe_n)
      else $error("program strobe while fetching internally");
   program_store_strobe_gate_a: assert property (
      $fell(bus_o.program_store_strobe_n) |->
      (!bus_o.program_store_strobe_n && !bus_o.p0_oe && bus_o.rd_n) [*4]
      ##1 (bus_o.program_store_strobe_n && fe_done_o && !fe_int_o))
      else $error("program strobe cycle malformed");
   fetch_addr_a: assert property (
      $fell(bus_o.program_store_strobe_n) |-> !ea_n_i && bus_o.p2_out == fe_addr_i[15:8]
      && $past(bus_o.p0_out) == fe_addr_i[7:0])
      else $error("fetch address wrong on the bus");
   fetch_int_a: assert property (
      fe_req_i && ea_n_i && !fe_done_o && !mv_req_i
      |=> fe_done_o && fe_int_o)
      else $error("internal fetch not answered next cycle");
   read_cycle_a: assert property (
      $fell(bus_o.rd_n) |-> (!bus_o.rd_n && !bus_o.p0_oe && bus_o.wr_n) [*4]
      ##1 (bus_o.rd_n && mv_done_o))
      else $error("external read cycle malformed");
   write_cycle_a: assert property (
      $fell(bus_o.wr_n) |-> (!bus_o.wr_n && bus_o.p0_oe) [*4]
      ##1 (bus_o.wr_n && mv_done_o))
      else $error("external write cycle malformed");
   move_addr_a: assert property (
      $fell(bus_o.rd_n) || $fell(bus_o.wr_n) |-> $past(bus_o.ale
      && bus_o.p0_out == (mv_data_pointer_i ? mv_data_pointer_val_i[7:0] : mv_ptr_i))
      && (!mv_data_pointer_i || bus_o.p2_out == mv_data_pointer_val_i[15:8]))
      else $error("move address not presented before data");
   aux_quiet_a: assert property (
      mv_done_o && $past(bus_o.rd_n && bus_o.wr_n) |-> !bus_o.p0_oe
      && $stable(bus_o.p2_out) && $past(mv_req_i && !mv_done_o))
      else $error("aux access disturbed the bus");
   sfr_hit_a: assert property (
      sp_req_i && !sp_ind_i |=> sfr_hit_o
      == $past(sp_addr_i inside {8'hA1, 8'hBF, 8'hF6}))
      else $error("register hit flag wrong");

   ext_read_c: cover property ($fell(bus_o.rd_n));
   ext_write_c: cover property ($fell(bus_o.wr_n));
   ext_fetch_c: cover property ($fell(bus_o.program_store_strobe_n));
   int_fetch_c: cover property (fe_done_o && fe_int_o);
endmodule

bind auxmem_top auxmem_checker u_chk (
   .core_clk_i, .rst_i, .ea_n_i, .sp_req_i, .sp_ind_i, .sp_addr_i,
   .sfr_hit_o, .mv_req_i, .mv_data_pointer_i, .mv_ptr_i, .mv_data_pointer_val_i,
   .mv_done_o, .fe_req_i, .fe_addr_i, .fe_int_o, .fe_done_o, .bus_o
);

// [verif/auxmem_ext_mem.sv]
// Behavioural external program ROM and data SRAM on the multiplexed bus
`timescale 1ns/100ps
module auxmem_ext_mem
   import auxmem_pkg::*;
(
   input  wire logic        core_clk_i, // Core clock
   input  wire auxmem_bus_t bus_i,      // Bus pins of the device
   output logic      [7:0]  p0_in_o     // Resolved port 0 level
);
   // ***********************************************
   // Address latch, memories and port 0 wire
   // ***********************************************
   logic       [7:0]  sram [0:65535];   // Data memory
   logic       [7:0]  lo_addr;          // Address latch contents
   logic       [7:0]  last = 8'h00;     // Last port 0 level
   wire  logic [15:0] addr = {bus_i.p2_out, lo_addr};

   // Latch is open while the strobe is high, holds after its fall
   always @(posedge core_clk_i) begin
      if (bus_i.ale && bus_i.p0_oe) begin
         lo_addr <= bus_i.p0_out;
      end
      if (!bus_i.wr_n) begin
         sram[addr] <= bus_i.p0_out;
      end
      last <= p0_in_o;
   end

   // Open drain without pull-up: a released line never shows stale data
   always_comb begin
      if (bus_i.p0_oe) begin
         p0_in_o = bus_i.p0_out;
      end else if (!bus_i.program_store_strobe_n) begin
         p0_in_o = addr[7:0] ^ addr[15:8] ^ 8'h5A;
      end else if (!bus_i.rd_n) begin
         p0_in_o = sram[addr];
      end else begin
         p0_in_o = ~last;
      end
   end
endmodule

// [verif/aux_ram_and_external_memory_access_tb_top.sv]
// Self-checking bench for the aux RAM and external memory access block
`timescale 1ns/100ps
module aux_ram_and_external_memory_access_tb_top
   import auxmem_pkg::*;
;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ea_n_i = 1'b1;
   logic        sp_req_i, sp_we_i, sp_ind_i, sfr_hit_o, hit;
   logic        mv_req_i, mv_we_i, mv_data_pointer_i, mv_done_o;
   logic        fe_req_i, fe_int_o, fe_done_o;
   logic [7:0]  sp_addr_i, sp_wdata_i, sp_rdata_o, mv_ptr_i, mv_wdata_i;
   logic [7:0]  mv_rdata_o, fe_data_o, p0_in_i, rd;
   logic [15:0] mv_data_pointer_val_i, fe_addr_i;
   logic [15:0] fa [3] = '{16'h0000, 16'hABCD, 16'hFFFF};
   auxmem_bus_t bus_o;
   int          fails = 0;
   int          checks = 0;
   int          n;

   auxmem_top u_dut (
      .core_clk_i, .rst_i, .ea_n_i, .sp_req_i, .sp_we_i, .sp_ind_i,
      .sp_addr_i, .sp_wdata_i, .sp_rdata_o, .sfr_hit_o, .mv_req_i, .mv_we_i,
      .mv_data_pointer_i, .mv_ptr_i, .mv_data_pointer_val_i, .mv_wdata_i, .mv_rdata_o,
      .mv_done_o, .fe_req_i, .fe_addr_i, .fe_data_o, .fe_int_o, .fe_done_o,
      .p0_in_i, .bus_o
   );
   auxmem_ext_mem u_mem (.core_clk_i, .bus_i(bus_o), .p0_in_o(p0_in_i));

   // ***********************************************
   // Clock, access tasks and verdict
   // ***********************************************
   initial forever #5 core_clk_i = ~core_clk_i;

   function automatic logic [7:0] rom(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction

   task automatic chk(input logic [15:0] got, exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      if (fails == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Request goes up just after a falling edge, answer read one cycle on
   task automatic sp(input logic we, ind, input logic [7:0] a, d);
      {sp_req_i, sp_we_i, sp_ind_i, sp_addr_i, sp_wdata_i}
         = {1'b1, we, ind, a, d};
      @(negedge core_clk_i);
      rd = sp_rdata_o;
      hit = sfr_hit_o;
      sp_req_i = 1'b0;
      @(negedge core_clk_i);
   endtask

   task automatic rdc(input logic ind, input logic [7:0] a, e, input logic h);
      sp(1'b0, ind, a, 8'h00);
      chk({7'h00, hit, rd}, {7'h00, h, e});
   endtask

   // Unlock, write the control register, then lock it again
   task automatic set_ctrl(input logic [7:0] v);
      sp(1'b1, 1'b0, 8'hF6, 8'h87);
      sp(1'b1, 1'b0, 8'hF6, 8'h59);
      sp(1'b1, 1'b0, 8'hBF, v);
      sp(1'b1, 1'b0, 8'hF6, 8'h00);
   endtask

   // Request held until the done pulse; n counts cycles to it
   task automatic mv(input logic we, dp, input logic [15:0] a,
                     input logic [7:0] d);
      {mv_req_i, mv_we_i, mv_data_pointer_i, mv_data_pointer_val_i, mv_ptr_i, mv_wdata_i}
         = {1'b1, we, dp, a, a[7:0], d};
      n = 0;
      do begin
         @(negedge core_clk_i);
         n++;
      end while (mv_done_o !== 1'b1 && n < 20);
      chk({15'h0, mv_done_o}, 16'h0001);
      rd = mv_rdata_o;
      mv_req_i = 1'b0;
      @(negedge core_clk_i);
   endtask

   task automatic fe(input logic [15:0] a);
      fe_req_i = 1'b1;
      fe_addr_i = a;
      n = 0;
      do begin
         @(negedge core_clk_i);
         n++;
      end while (fe_done_o !== 1'b1 && n < 20);
      chk({15'h0, fe_done_o}, 16'h0001);
      rd = fe_data_o;
      hit = fe_int_o;
      fe_req_i = 1'b0;
      @(negedge core_clk_i);
   endtask

   // Pulses under two machine cycles must be ignored
   task automatic pulse_rst(input int len);
      rst_i = 1'b1;
      repeat (len) @(negedge core_clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
   endtask

   // Watchdog sized well above the few hundred cycles the tests need
   initial begin
      #200000;
      fails++;
      summarize();
   end

   // ***********************************************
   // Test sequence
   // ***********************************************
   initial begin
      {sp_req_i, sp_we_i, sp_ind_i, sp_addr_i, sp_wdata_i} = '0;
      {mv_req_i, mv_we_i, mv_data_pointer_i, mv_data_pointer_val_i, mv_ptr_i, mv_wdata_i} = '0;
      {fe_req_i, fe_addr_i} = '0;
      pulse_rst(30);
      rdc(1'b0, 8'hBF, 8'h00, 1'b1);
      rdc(1'b0, 8'hA1, 8'h00, 1'b1);
      rdc(1'b0, 8'hF6, 8'h00, 1'b1);
      rdc(1'b0, 8'hC0, 8'h00, 1'b0);
      // Locked control register ignores a write
      sp(1'b1, 1'b0, 8'hBF, 8'h10);
      rdc(1'b0, 8'hBF, 8'h00, 1'b1);
      set_ctrl(8'h10);
      sp(1'b1, 1'b0, 8'hBF, 8'h00);
      rdc(1'b0, 8'hBF, 8'h10, 1'b1);
      // Scratchpad halves and their addressing modes
      sp(1'b1, 1'b0, 8'h20, 8'h5A);
      rdc(1'b1, 8'h20, 8'h5A, 1'b0);
      sp(1'b1, 1'b1, 8'h7F, 8'hC3);
      rdc(1'b0, 8'h7F, 8'hC3, 1'b0);
      sp(1'b1, 1'b1, 8'h90, 8'hA5);
      sp(1'b1, 1'b0, 8'h90, 8'h11);
      rdc(1'b1, 8'h90, 8'hA5, 1'b0);
      rdc(1'b0, 8'h90, 8'h00, 1'b0);
      // Aux RAM through pointer plus high byte and through data pointer
      sp(1'b1, 1'b0, 8'hA1, 8'h01);
      mv(1'b1, 1'b0, 16'h0023, 8'h55);
      mv(1'b1, 1'b1, 16'h0134, 8'h78);
      mv(1'b0, 1'b1, 16'h0123, 8'h00);
      chk({rd, n[7:0]}, 16'h5501);
      mv(1'b0, 1'b0, 16'h0034, 8'h00);
      chk({8'h00, rd}, 16'h0078);
      mv(1'b1, 1'b1, 16'h03FF, 8'hE7);
      mv(1'b0, 1'b1, 16'h03FF, 8'h00);
      chk({rd, n[7:0]}, 16'hE701);
      // Just above the aux range the move leaves the chip
      mv(1'b1, 1'b1, 16'h0400, 8'h96);
      mv(1'b0, 1'b1, 16'h0400, 8'h00);
      chk({rd, u_mem.sram[16'h0400]}, 16'h9696);
      chk({15'h0, n >= 6 && n <= 11}, 16'h0001);
      // Routing bit clear: the same low address goes to the bus
      set_ctrl(8'h00);
      mv(1'b1, 1'b1, 16'h0123, 8'h3C);
      mv(1'b0, 1'b1, 16'h0123, 8'h00);
      chk({rd, u_mem.sram[16'h0123]}, 16'h3C3C);
      sp(1'b1, 1'b0, 8'hA1, 8'h7F);
      mv(1'b1, 1'b0, 16'h00FF, 8'h69);
      chk({8'h00, u_mem.sram[16'h7FFF]}, 16'h0069);
      set_ctrl(8'h10);
      mv(1'b0, 1'b1, 16'h0123, 8'h00);
      chk({8'h00, rd}, 16'h0055);
      // Internal fetch answers at once, external ones run a strobe cycle
      fe(16'h1234);
      chk({7'h00, hit, n[7:0]}, 16'h0101);
      ea_n_i = 1'b0;
      foreach (fa[i]) begin
         fe(fa[i]);
         chk({rd, 7'h00, hit}, {rom(fa[i]), 8'h00});
         chk({15'h0, n >= 6 && n <= 11}, 16'h0001);
      end
      ea_n_i = 1'b1;
      // Short reset pulse keeps state, a full one clears it
      pulse_rst(10);
      rdc(1'b0, 8'hBF, 8'h10, 1'b1);
      pulse_rst(30);
      rdc(1'b0, 8'hBF, 8'h00, 1'b1);
      rdc(1'b0, 8'hA1, 8'h00, 1'b1);
      summarize();
   end
endmodule
